// ---- hw/fet_ctrl_pkg.sv ----
// constants shared by the host measurement and fet override block
package fet_ctrl_pkg;

  // register offsets on the i2c register map
  localparam logic [7:0] MEAS_CTRL_ADDR = 8'h85;
  localparam logic [7:0] HOST_CTRL_ADDR = 8'h86;
  localparam logic [7:0] STATUS_ADDR    = 8'h87;
  localparam logic [7:0] RESULT_LO_ADDR = 8'haa;
  localparam logic [7:0] RESULT_HI_ADDR = 8'hab;

  // measurement control fields
  localparam int MEAS_SEL_LSB   = 0;
  localparam int MEAS_SEL_W     = 4;
  localparam int MEAS_GAIN_LSB  = 4;
  localparam int MEAS_GAIN_W    = 2;
  localparam int MEAS_START_BIT = 7;

  // host control fields
  localparam int HOST_SCAN_BIT  = 0;
  localparam int HOST_FETS_BIT  = 1;
  localparam int HOST_HOST_FET_OVERRIDE_BIT  = 2;
  localparam int HOST_DFET_BIT  = 3;
  localparam int HOST_PCFET_BIT = 4;

  // reset values
  localparam logic [7:0] MEAS_CTRL_RST = 8'h00;
  localparam logic [7:0] HOST_CTRL_RST = 8'h00;
  localparam logic [7:0] PTR_RST       = 8'h00;

  // i2c slave address, value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h28;

  // adc conversion time, rounded up to whole mclk cycles
  localparam int MCLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS   = 100000;
  localparam int CONV_CYCLES    =
    (CONV_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int CONV_CNT_W     = 11;
  localparam logic [CONV_CNT_W-1:0] CONV_CNT_LAST =
    CONV_CNT_W'(CONV_CYCLES - 1);

  localparam int RESULT_W = 14;

  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_WRITE, I2C_WRITE_ACK,
    I2C_READ, I2C_READ_ACK, I2C_READ_NEXT
  } i2c_state_t;

endpackage : fet_ctrl_pkg

// ---- hw/i2c_regs_if.sv ----
// byte-level link between the i2c slave and the register file
`timescale 1ns/1ps
`default_nettype none
interface i2c_regs_if;
  logic       wr_en;
  logic [7:0] wr_data;
  logic       first_byte;
  logic       rd_adv;
  logic [7:0] rd_data;
  logic       hold_off;

  modport slave (output wr_en, wr_data, first_byte, rd_adv,
                 input  rd_data, hold_off);
  modport regs  (input  wr_en, wr_data, first_byte, rd_adv,
                 output rd_data, hold_off);
endinterface : i2c_regs_if
`default_nettype wire

// ---- hw/i2c_reg_slave.sv ----
// i2c slave byte engine, scl and sda sampled by mclk
`timescale 1ns/1ps
`default_nettype none
module i2c_reg_slave (
  // clock and reset
  input  wire logic   mclk,
  input  wire logic   rst,
  // i2c pins
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  output logic        sda_oe,
  // register side
  i2c_regs_if.slave   bus
);

  logic [1:0]              scl_s;
  logic [1:0]              sda_s;
  logic                    scl_d;
  logic                    sda_d;
  logic [7:0]              sh;
  logic [3:0]              cnt;
  logic                    rw;
  fet_ctrl_pkg::i2c_state_t state;

  wire scl_rise = scl_s[1] & ~scl_d;
  wire scl_fall = ~scl_s[1] & scl_d;
  wire start_w  = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  wire stop_w   = scl_s[1] & scl_d & ~sda_d & sda_s[1];
  wire addr_hit = (sh[7:1] == fet_ctrl_pkg::DEV_ADDR);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state          <= fet_ctrl_pkg::I2C_IDLE;
      sh             <= 8'h00;
      cnt            <= 4'h0;
      rw             <= 1'b0;
      sda_oe         <= 1'b0;
      bus.wr_en      <= 1'b0;
      bus.wr_data    <= 8'h00;
      bus.first_byte <= 1'b0;
      bus.rd_adv     <= 1'b0;
    end else begin
      bus.wr_en  <= 1'b0;
      bus.rd_adv <= 1'b0;
      if (start_w) begin
        state  <= fet_ctrl_pkg::I2C_ADDR;
        cnt    <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_w) begin
        state  <= fet_ctrl_pkg::I2C_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          fet_ctrl_pkg::I2C_IDLE: begin
          end
          fet_ctrl_pkg::I2C_ADDR: begin
            if (scl_rise) begin
              sh  <= {sh[6:0], sda_s[1]};
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt == 4'h8) begin
              // address is refused while a conversion runs
              if (addr_hit && !bus.hold_off) begin
                sda_oe <= 1'b1;
                rw     <= sh[0];
                state  <= fet_ctrl_pkg::I2C_ADDR_ACK;
              end else begin
                state <= fet_ctrl_pkg::I2C_IDLE;
              end
            end
          end
          fet_ctrl_pkg::I2C_ADDR_ACK: begin
            if (scl_fall) begin
              cnt <= 4'h0;
              if (rw) begin
                sh         <= bus.rd_data;
                bus.rd_adv <= 1'b1;
                sda_oe     <= ~bus.rd_data[7];
                state      <= fet_ctrl_pkg::I2C_READ;
              end else begin
                sda_oe         <= 1'b0;
                bus.first_byte <= 1'b1;
                state          <= fet_ctrl_pkg::I2C_WRITE;
              end
            end
          end
          fet_ctrl_pkg::I2C_WRITE: begin
            if (scl_rise) begin
              sh  <= {sh[6:0], sda_s[1]};
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt == 4'h8) begin
              sda_oe      <= 1'b1;
              bus.wr_en   <= 1'b1;
              bus.wr_data <= sh;
              state       <= fet_ctrl_pkg::I2C_WRITE_ACK;
            end
          end
          fet_ctrl_pkg::I2C_WRITE_ACK: begin
            if (scl_fall) begin
              sda_oe         <= 1'b0;
              bus.first_byte <= 1'b0;
              cnt            <= 4'h0;
              state          <= fet_ctrl_pkg::I2C_WRITE;
            end
          end
          fet_ctrl_pkg::I2C_READ: begin
            if (scl_fall) begin
              if (cnt == 4'h7) begin
                sda_oe <= 1'b0;
                state  <= fet_ctrl_pkg::I2C_READ_ACK;
              end else begin
                sh     <= {sh[6:0], 1'b0};
                sda_oe <= ~sh[6];
                cnt    <= cnt + 4'h1;
              end
            end
          end
          fet_ctrl_pkg::I2C_READ_ACK: begin
            if (scl_rise) begin
              state <= sda_s[1] ? fet_ctrl_pkg::I2C_IDLE
                                : fet_ctrl_pkg::I2C_READ_NEXT;
            end
          end
          fet_ctrl_pkg::I2C_READ_NEXT: begin
            if (scl_fall) begin
              sh         <= bus.rd_data;
              bus.rd_adv <= 1'b1;
              sda_oe     <= ~bus.rd_data[7];
              cnt        <= 4'h0;
              state      <= fet_ctrl_pkg::I2C_READ;
            end
          end
        endcase
      end
    end
  end

endmodule : i2c_reg_slave
`default_nettype wire

// ---- hw/host_measure_fet_override.sv ----
// host scan takeover, single conversions and host fet override
//
// Summary of operation
// - setting scan takeover halts the internal scan and starts the watchdog
// - takeover or fet override hands pack control to host while either is set
// - during takeover host selects input, sets start bit; device starts one conversion
// - each conversion result is kept as 14 bits in the result registers
// - conversion takes about 100 us; address is not acknowledged meanwhile
// - a scan falling due during takeover runs as soon as takeover clears
// - a two-bit gain field in measurement control sets current sense gain
// - with fet override set the host switches the fets freely
// - discharge short circuit turns fets off even under override
// - internal over-temperature turns fets off even under override
// - overvoltage lockout turns charge and precharge fets off
// - open sense wire turns fets off even under override
// - fets stay off while the force-off input is high
// - entering sleep turns fets off even under override
// - during takeover only short circuit and force-off still act on fets
// - force-off beats every other fet control source
`timescale 1ns/1ps
`default_nettype none
module host_measure_fet_override (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // i2c pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // pack protection events
  input  wire logic        short_circuit,
  input  wire logic        internal_overtemp,
  input  wire logic        overvoltage_lockout,
  input  wire logic        open_wire,
  input  wire logic        sleep_entry,
  input  wire logic        fets_force_off,
  // automatic fet requests
  input  wire logic        auto_host_fet_override,
  input  wire logic        auto_dfet,
  input  wire logic        auto_pcfet,
  // internal scan scheduler
  input  wire logic        scan_due,
  output logic             scan_halt,
  output logic             scan_run,
  output logic             watchdog_start,
  output logic             host_pack_control,
  // adc
  input  wire logic [13:0] adc_data,
  output logic             adc_start,
  output logic [3:0]       adc_select,
  output logic [1:0]       current_gain_select,
  // power fets
  output logic             host_fet_override_on,
  output logic             dfet_on,
  output logic             pcfet_on
);

  i2c_regs_if bus ();

  logic [1:0]                           foff_s;
  logic [7:0]                           meas_ctrl_r;
  logic [7:0]                           host_ctrl_r;
  logic [7:0]                           host_ctrl_nxt;
  logic [7:0]                           ptr_r;
  logic [fet_ctrl_pkg::RESULT_W-1:0]    result_r;
  logic                                 busy_r;
  logic [fet_ctrl_pkg::CONV_CNT_W-1:0]  conv_cnt_r;
  logic                                 pending_r;
  logic                                 host_fet_override_r;
  logic                                 dfet_r;
  logic                                 pcfet_r;

  i2c_reg_slave u_slave (
    .mclk   (mclk),
    .rst    (rst),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .sda_oe (sda_oe),
    .bus    (bus.slave)
  );

  assign sda_out = 1'b0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      foff_s <= 2'h0;
    end else begin
      foff_s <= {foff_s[0], fets_force_off};
    end
  end

  // register decode
  wire force_off = foff_s[1];
  wire takeover  = host_ctrl_r[fet_ctrl_pkg::HOST_SCAN_BIT];
  wire override  = host_ctrl_r[fet_ctrl_pkg::HOST_FETS_BIT];
  wire wr_reg    = bus.wr_en & ~bus.first_byte;
  wire wr_meas   = wr_reg & (ptr_r == fet_ctrl_pkg::MEAS_CTRL_ADDR);
  wire wr_host   = wr_reg & (ptr_r == fet_ctrl_pkg::HOST_CTRL_ADDR);
  wire conv_done = busy_r & (conv_cnt_r == fet_ctrl_pkg::CONV_CNT_LAST);
  wire [7:0] status_w = {3'h0, pcfet_r, dfet_r, host_fet_override_r, pending_r, busy_r};
  wire [7:0] meas_rd  = {busy_r, meas_ctrl_r[6:0]};
  wire [7:0] res_lo   = result_r[7:0];
  wire [7:0] res_hi   = {2'h0, result_r[13:8]};

  assign bus.rd_data =
    (ptr_r == fet_ctrl_pkg::MEAS_CTRL_ADDR) ? meas_rd     :
    (ptr_r == fet_ctrl_pkg::HOST_CTRL_ADDR) ? host_ctrl_r :
    (ptr_r == fet_ctrl_pkg::STATUS_ADDR)    ? status_w    :
    (ptr_r == fet_ctrl_pkg::RESULT_LO_ADDR) ? res_lo      :
    (ptr_r == fet_ctrl_pkg::RESULT_HI_ADDR) ? res_hi      : 8'h00;

  assign bus.hold_off = busy_r;

  // start one conversion on start bit
  wire conv_go = wr_meas & bus.wr_data[fet_ctrl_pkg::MEAS_START_BIT]
               & takeover & ~busy_r;

  // held takeover or override hands fets to host
  wire host_mode = override | takeover;

  wire kill_hard = short_circuit | force_off;
  wire kill_all  = kill_hard
                 | (override & ~takeover
                    & (internal_overtemp | open_wire | sleep_entry));
  wire kill_chg  = kill_all | (override & ~takeover & overvoltage_lockout);

  wire [7:0] kill_mask =
      ({7'h00, kill_chg} << fet_ctrl_pkg::HOST_HOST_FET_OVERRIDE_BIT)
    | ({7'h00, kill_chg} << fet_ctrl_pkg::HOST_PCFET_BIT)
    | ({7'h00, kill_all} << fet_ctrl_pkg::HOST_DFET_BIT);

  // host fet bits are cleared by shutdown, host must turn them back on
  always_comb begin
    host_ctrl_nxt = wr_host ? bus.wr_data : host_ctrl_r;
    host_ctrl_nxt = host_ctrl_nxt & ~kill_mask;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meas_ctrl_r <= fet_ctrl_pkg::MEAS_CTRL_RST;
      host_ctrl_r <= fet_ctrl_pkg::HOST_CTRL_RST;
      ptr_r       <= fet_ctrl_pkg::PTR_RST;
    end else begin
      if (wr_meas) begin
        meas_ctrl_r <= bus.wr_data;
      end
      host_ctrl_r <= host_ctrl_nxt;
      if (bus.wr_en && bus.first_byte) begin
        ptr_r <= bus.wr_data;
      end else if (wr_reg || bus.rd_adv) begin
        ptr_r <= ptr_r + 8'h01;
      end
    end
  end

  // gain and input select drive the analog front end
  assign current_gain_select =
    meas_ctrl_r[fet_ctrl_pkg::MEAS_GAIN_LSB +: fet_ctrl_pkg::MEAS_GAIN_W];
  assign adc_select =
    meas_ctrl_r[fet_ctrl_pkg::MEAS_SEL_LSB +: fet_ctrl_pkg::MEAS_SEL_W];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_r     <= 1'b0;
      conv_cnt_r <= '0;
      adc_start  <= 1'b0;
      result_r   <= '0;
    end else begin
      adc_start <= conv_go;
      if (conv_go) begin
        busy_r     <= 1'b1;
        conv_cnt_r <= '0;
      end else if (conv_done) begin
        busy_r <= 1'b0;
        // raw 14-bit code kept at adc scale
        result_r <= adc_data;
      end else if (busy_r) begin
        conv_cnt_r <= conv_cnt_r + 1'b1;
      end
    end
  end

  // takeover halts the scan, rising edge starts watchdog
  assign scan_halt         = takeover;
  assign host_pack_control = host_mode;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      watchdog_start <= 1'b0;
      pending_r      <= 1'b0;
      scan_run       <= 1'b0;
    end else begin
      watchdog_start <= ~takeover & host_ctrl_nxt[fet_ctrl_pkg::HOST_SCAN_BIT];
      // hold a due scan, release it once takeover clears
      scan_run  <= ~takeover & (scan_due | pending_r);
      pending_r <= takeover & (scan_due | pending_r);
    end
  end

  // fet drive, force-off and short above every source
  wire host_fet_override_nxt  = ~kill_hard & (host_mode
                   ? host_ctrl_nxt[fet_ctrl_pkg::HOST_HOST_FET_OVERRIDE_BIT]  : auto_host_fet_override);
  wire dfet_nxt  = ~kill_hard & (host_mode
                   ? host_ctrl_nxt[fet_ctrl_pkg::HOST_DFET_BIT]  : auto_dfet);
  wire pcfet_nxt = ~kill_hard & (host_mode
                   ? host_ctrl_nxt[fet_ctrl_pkg::HOST_PCFET_BIT] : auto_pcfet);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      host_fet_override_r  <= 1'b0;
      dfet_r  <= 1'b0;
      pcfet_r <= 1'b0;
    end else begin
      host_fet_override_r  <= host_fet_override_nxt;
      dfet_r  <= dfet_nxt;
      pcfet_r <= pcfet_nxt;
    end
  end

  assign host_fet_override_on  = host_fet_override_r;
  assign dfet_on  = dfet_r;
  assign pcfet_on = pcfet_r;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_conv_req;
    conv_go;
  endsequence

  sequence s_fets_off;
    !host_fet_override_r && !dfet_r && !pcfet_r;
  endsequence

  property p_watchdog;
    $rose(takeover) |-> watchdog_start && scan_halt;
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("watchdog not started on takeover");

  property p_conv_start;
    s_conv_req |=> busy_r && adc_start ##1 busy_r && !adc_start;
  endproperty
  a_conv_start: assert property (p_conv_start)
    else $error("conversion did not start");

  property p_conv_len;
    $fell(busy_r) |-> $past(conv_cnt_r) == fet_ctrl_pkg::CONV_CNT_LAST;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");

  property p_result;
    $fell(busy_r) |-> result_r == $past(adc_data) && !bus.hold_off;
  endproperty
  a_result: assert property (p_result)
    else $error("result not captured");

  property p_scan_defer;
    pending_r && !takeover |=> scan_run && !pending_r;
  endproperty
  a_scan_defer: assert property (p_scan_defer)
    else $error("deferred scan not run");

  property p_force_off;
    force_off |=> s_fets_off;
  endproperty
  a_force_off: assert property (p_force_off)
    else $error("fets on during force-off");

  property p_short;
    short_circuit |=> s_fets_off ##1
      (host_ctrl_r[4:2] == 3'h0 || !$past(short_circuit));
  endproperty
  a_short: assert property (p_short)
    else $error("fets on during short circuit");

  property p_overvoltage_lockout;
    overvoltage_lockout && override && !takeover |=> !host_fet_override_r && !pcfet_r;
  endproperty
  a_overvoltage_lockout: assert property (p_overvoltage_lockout)
    else $error("charge fet on during lockout");

  property p_events;
    override && !takeover && (internal_overtemp || open_wire || sleep_entry)
      |=> s_fets_off;
  endproperty
  a_events: assert property (p_events)
    else $error("fets on after shutdown event");

  property p_host_free;
    override && !kill_chg && !wr_host |=>
      host_fet_override_r == $past(host_ctrl_r[fet_ctrl_pkg::HOST_HOST_FET_OVERRIDE_BIT]);
  endproperty
  a_host_free: assert property (p_host_free)
    else $error("host fet request not followed");

endmodule : host_measure_fet_override
`default_nettype wire

// ---- sim/i2c_host_model.sv ----
// i2c master model standing in for the host microcontroller
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  // i2c lines, sda is the resolved wire level
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  localparam time Q = 100;

  // scl idles high between frames, sda released
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  // start or repeated start: sda falls while scl high
  task automatic start_c();
    sda_m = 1'b1;
    #Q scl = 1'b1;
    #Q sda_m = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask : start_c

  task automatic stop_c();
    sda_m = 1'b0;
    #Q scl = 1'b1;
    #Q sda_m = 1'b1;
    #(2*Q);
  endtask : stop_c

  // data changes mid-low, wire sampled at the end of the high phase
  task automatic bit_c(input logic b, output logic r);
    sda_m = b;
    #Q scl = 1'b1;
    #(2*Q-1) r = sda;
    #1 scl = 1'b0;
    #Q;
  endtask : bit_c

  // ninth bit always released: ack on writes, nack ends reads
  task automatic byte_c(input logic [7:0] d, output logic [7:0] q,
                        output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(d[i], r);
      q[i] = r;
    end
    bit_c(1'b1, r);
    ack = ~r;
  endtask : byte_c

  // pointer write then data byte or repeated start and one read
  task automatic xfer(input logic rd, input logic [7:0] ofs,
                      input logic [7:0] wd, output logic [7:0] q,
                      output logic ack);
    logic [7:0] x;
    logic       a;
    q = 8'h00;
    start_c();
    byte_c({fet_ctrl_pkg::DEV_ADDR, 1'b0}, x, ack);
    if (ack) begin
      byte_c(ofs, x, a);
      if (rd) begin
        start_c();
        byte_c({fet_ctrl_pkg::DEV_ADDR, 1'b1}, x, a);
        byte_c(8'hff, q, a);
      end else begin
        byte_c(wd, x, a);
      end
    end
    stop_c();
  endtask : xfer
endmodule : i2c_host_model
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for host measurement and fet override
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk;
  logic        rst;
  logic        scan_due;
  logic [5:0]  evt;
  logic [2:0]  auto_f;
  logic [13:0] adc_data;
  logic [7:0]  rd;
  logic        ack;
  logic [7:0]  hi_b;
  int          hv;
  wire logic   scl, sda_m, sda, sda_out, sda_oe, scan_halt, scan_run;
  wire logic   wd_start, hpc, adc_start, host_fet_override, dfet, pcfet;
  wire logic [3:0] adc_sel;
  wire logic [1:0] gain;
  wire logic [2:0] fets;
  integer      mismatches, total_checks, cycles, n_start, n_wd, n_run;

  // open drain sda with pull-up
  assign sda  = sda_m & ~(sda_oe & ~sda_out);
  assign fets = {pcfet, dfet, host_fet_override};

  host_measure_fet_override host_measure_fet_override_i (
    .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .short_circuit(evt[0]), .internal_overtemp(evt[1]),
    .overvoltage_lockout(evt[2]), .open_wire(evt[3]),
    .sleep_entry(evt[4]), .fets_force_off(evt[5]),
    .auto_host_fet_override(auto_f[0]), .auto_dfet(auto_f[1]), .auto_pcfet(auto_f[2]),
    .scan_due(scan_due), .scan_halt(scan_halt), .scan_run(scan_run),
    .watchdog_start(wd_start), .host_pack_control(hpc),
    .adc_data(adc_data), .adc_start(adc_start), .adc_select(adc_sel),
    .current_gain_select(gain),
    .host_fet_override_on(host_fet_override), .dfet_on(dfet), .pcfet_on(pcfet));

  i2c_host_model i2c_host_model_i (.scl(scl), .sda_m(sda_m), .sda(sda));

  always #25 mclk = ~mclk;

  task automatic end_sim();
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // pulse counters and run ceiling
  always @(posedge mclk) begin
    cycles++;
    if (adc_start === 1'b1) n_start++;
    if (wd_start === 1'b1) n_wd++;
    if (scan_run === 1'b1) n_run++;
    if (cycles == 40000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // host view of a code, offset removed at zero flow
  function automatic int host_code(input int raw, input int offs,
                                   input logic flow);
    int v;
    v = (raw >= 8191) ? raw - 16384 : raw;
    if (!flow) begin
      v = v - offs;
      if (v < 0) begin
        v = -v;
      end
    end
    return v;
  endfunction : host_code

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    i2c_host_model_i.xfer(1'b0, o, d, rd, ack);
    chk("write_ack", 8'h01, {7'h00, ack});
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] o,
                     input logic [7:0] e);
    i2c_host_model_i.xfer(1'b1, o, 8'h00, rd, ack);
    chk("read_ack", 8'h01, {7'h00, ack});
    chk(nm, e, rd);
  endtask : rdc

  task automatic pulse_due();
    @(posedge mclk);
    scan_due <= 1'b1;
    @(posedge mclk);
    scan_due <= 1'b0;
    cyc(3);
  endtask : pulse_due

  // host fet setting, then one event raised and dropped
  task automatic fet_case(input logic [7:0] h, input logic [5:0] m,
                          input logic [2:0] d, input logic [2:0] a);
    wr(8'h86, h);
    chk("fets_host", {5'h00, h[4:2]}, {5'h00, fets});
    @(posedge mclk);
    evt <= m;
    cyc(5);
    chk("fets_event", {5'h00, d}, {5'h00, fets});
    @(posedge mclk);
    evt <= 6'h00;
    cyc(5);
    chk("fets_after", {5'h00, a}, {5'h00, fets});
  endtask : fet_case

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    scan_due = 1'b0;
    evt = 6'h00;
    auto_f = 3'b101;
    adc_data = 14'h3f81;
    {mismatches, total_checks, cycles, n_start, n_wd, n_run} = '0;
    repeat (10) @(posedge mclk);
    chk("fets_reset", 8'h00, {5'h00, fets});
    rst <= 1'b0;
    cyc(4);
    chk("fets_auto", 8'h05, {5'h00, fets});
    @(posedge mclk);
    evt <= 6'h01;
    cyc(3);
    chk("fets_auto_short", 8'h00, {5'h00, fets});
    @(posedge mclk);
    evt <= 6'h00;
    cyc(3);
    chk("fets_auto_back", 8'h05, {5'h00, fets});
    rdc("meas_ctrl", 8'h85, 8'h00);
    rdc("host_ctrl", 8'h86, 8'h00);
    rdc("unmapped", 8'h90, 8'h00);
    wr(8'h86, 8'h02);
    chk("fets_override", 8'h00, {5'h00, fets});
    wr(8'h86, 8'h00);
    pulse_due();
    chk("scan_run_free", 8'h01, n_run[7:0]);
    wr(8'h85, 8'h80);
    chk("start_no_takeover", 8'h00, n_start[7:0]);
    rdc("host_ctrl", 8'h86, 8'h00);
    wr(8'h86, rd | 8'h01);
    chk("scan_halt", 8'h01, {7'h00, scan_halt});
    chk("watchdog", 8'h01, n_wd[7:0]);
    chk("pack_ctrl", 8'h01, {7'h00, hpc});
    pulse_due();
    chk("scan_held", 8'h01, n_run[7:0]);
    wr(8'h85, 8'ha5);
    chk("adc_start", 8'h01, n_start[7:0]);
    chk("adc_sel", 8'h05, {4'h0, adc_sel});
    chk("gain", 8'h02, {6'h00, gain});
    i2c_host_model_i.xfer(1'b1, 8'hab, 8'h00, rd, ack);
    chk("busy_nack", 8'h00, {7'h00, ack});
    repeat (40) begin
      if (ack !== 1'b1) begin
        i2c_host_model_i.xfer(1'b1, 8'hab, 8'h00, rd, ack);
      end
    end
    rdc("result_hi", 8'hab, 8'h3f);
    hi_b = rd;
    rdc("result_lo", 8'haa, 8'h81);
    hv = host_code({hi_b[5:0], rd}, 0, 1'b1);
    chk("host_signed", 8'hff, hv[15:8]);
    hv = host_code({hi_b[5:0], rd}, -100, 1'b0);
    chk("host_offset", 8'h1b, hv[7:0]);
    rdc("meas_ctrl", 8'h85, 8'h25);
    rdc("host_ctrl", 8'h86, 8'h01);
    wr(8'h86, rd & 8'hfe);
    chk("scan_release", 8'h02, n_run[7:0]);
    chk("scan_halt_off", 8'h00, {7'h00, scan_halt});
    fet_case(8'h1e, 6'h01, 3'b000, 3'b000);
    fet_case(8'h1e, 6'h02, 3'b000, 3'b000);
    fet_case(8'h1e, 6'h04, 3'b010, 3'b010);
    rdc("host_ctrl", 8'h86, 8'h0a);
    rdc("status", 8'h87, 8'h08);
    fet_case(8'h1e, 6'h08, 3'b000, 3'b000);
    fet_case(8'h1e, 6'h10, 3'b000, 3'b000);
    fet_case(8'h1e, 6'h20, 3'b000, 3'b000);
    fet_case(8'h1d, 6'h02, 3'b111, 3'b111);
    fet_case(8'h1d, 6'h01, 3'b000, 3'b000);
    rdc("host_ctrl", 8'h86, 8'h01);
    fet_case(8'h1d, 6'h20, 3'b000, 3'b000);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
